// *** bench/boot_strap_sampler_tb.sv ***
// self-checking bench for the strap sampler
`timescale 1ns/1ps
module boot_strap_sampler_tb;
    localparam logic [31:0] SOFT_ADDR = 32'h0000_0100;
    logic clk_sys, rst, resume_well_reset_n, core_power_good, drive_en;
    logic [2:0] strap_lvl, strap_pin, pd_en;
    logic flash_rd_req, flash_rd_valid, fetch_is_hub, me_reset_n, host_reset_n;
    logic [31:0] flash_rd_addr, flash_rd_data, fetch_addr_in, fetch_addr_out, soft_word;
    logic watchdog_reboot_en, encrypt_suite_en;
    logic [7:0] flash_wait;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int err_total = 0;
    int tests_run = 0;
    int flash_pulses = 0;
    // fields per boot: swap, noreboot, encrypt, block size
    logic [4:0] boot_tbl [4] = '{5'b11000, 5'b10101, 5'b01110, 5'b10011};

    boot_strap_sampler #(.SOFT_STRAP_ADDR(SOFT_ADDR)) uut (
        .clk_sys(clk_sys), .rst(rst), .resume_well_reset_n(resume_well_reset_n),
        .core_power_good(core_power_good), .speaker_swap_strap_pin(strap_pin[2]),
        .noreboot_strap_pin(strap_pin[1]), .encrypt_strap_pin(strap_pin[0]),
        .speaker_swap_pd_en(pd_en[2]), .noreboot_pd_en(pd_en[1]), .encrypt_pd_en(pd_en[0]),
        .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
        .flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data),
        .fetch_addr_in(fetch_addr_in), .fetch_is_hub(fetch_is_hub),
        .fetch_addr_out(fetch_addr_out), .me_reset_n(me_reset_n), .host_reset_n(host_reset_n),
        .watchdog_reboot_en(watchdog_reboot_en), .encrypt_suite_en(encrypt_suite_en),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    strap_board_model board (
        .clk_sys(clk_sys), .drive_en(drive_en), .strap_lvl(strap_lvl), .pd_en(pd_en),
        .strap_pin(strap_pin), .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
        .flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data),
        .soft_word(soft_word), .soft_addr(SOFT_ADDR), .flash_wait(flash_wait)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (flash_rd_valid === 1'b1) flash_pulses++;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    // address and data offered together, each released when taken
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        @(posedge clk_sys);
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar;
        @(posedge clk_sys);
        ar = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (!ar && s_axi_arready === 1'b1) begin
                ar = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read

    // full power-up: resume well first, then core power good
    task automatic boot(input logic [4:0] cfg, input logic [7:0] fw);
        logic [31:0] d;
        logic [1:0]  r;
        int          start, n;
        resume_well_reset_n <= 1'b0;
        core_power_good <= 1'b0;
        drive_en <= 1'b1;
        strap_lvl <= {cfg[4], cfg[3], cfg[2]};
        soft_word <= {30'h1234_5678, cfg[1:0]};
        flash_wait <= fw;
        repeat (40) @(posedge clk_sys);
        check("reboot default", {31'h0, watchdog_reboot_en}, 32'h1);
        check("cipher default", {31'h0, encrypt_suite_en}, 32'h0);
        check("pulldowns on", {29'h0, pd_en}, 32'h7);
        check("me held", {31'h0, me_reset_n}, 32'h0);
        axi_read(12'h0dc, d, r);
        check("swap default", {31'h0, d[4]}, 32'h0);
        start = flash_pulses;
        resume_well_reset_n <= 1'b1;
        n = 0;
        while (me_reset_n !== 1'b1 && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        check("fetch before me", flash_pulses - start, 32'h1);
        check("host held", {31'h0, host_reset_n}, 32'h0);
        check("cipher strap", {31'h0, encrypt_suite_en}, {31'h0, cfg[2]});
        check("resume pulldown", {29'h0, pd_en}, 32'h6);
        repeat (40) @(posedge clk_sys);
        core_power_good <= 1'b1;
        repeat (20) @(posedge clk_sys);
        check("reboot strap", {31'h0, watchdog_reboot_en}, {31'h0, ~cfg[3]});
        check("pg pulldown", {29'h0, pd_en}, 32'h0);
        check("host out", {31'h0, host_reset_n}, 32'h1);
        axi_read(12'h0e0, d, r);
        check("status", d, {27'h0, 3'b111, cfg[2], cfg[3]});
        axi_read(12'h0e4, d, r);
        check("blk size", d, {30'h0, cfg[1:0]});
        axi_read(12'h0e8, d, r);
        check("soft word", d, {30'h1234_5678, cfg[1:0]});
        drive_en <= 1'b0;
        strap_lvl <= ~{cfg[4], cfg[3], cfg[2]};
        repeat (20) @(posedge clk_sys);
        axi_read(12'h0dc, d, r);
        check("swap bit", {31'h0, d[4]}, {31'h0, cfg[4]});
        check("reboot kept", {31'h0, watchdog_reboot_en}, {31'h0, ~cfg[3]});
        check("cipher kept", {31'h0, encrypt_suite_en}, {31'h0, cfg[2]});
    endtask : boot

    // hub upper block, hub lower block, serial flash
    task automatic swap_addr(input logic sw, input logic [1:0] bk);
        logic [31:0] a, e;
        int          b;
        b = 16 + ((bk > 2'h1) ? 2 : int'(bk));
        for (int i = 0; i < 3; i++) begin
            a = (i == 0) ? 32'hfffe_5678 : (i == 1) ? 32'h000f_1234 : 32'h0003_4560;
            e = a;
            if (sw && i != 1) e[b] = ~e[b];
            @(posedge clk_sys);
            fetch_addr_in <= a;
            fetch_is_hub <= (i < 2);
            repeat (2) @(posedge clk_sys);
            check("fetch addr", fetch_addr_out, e);
        end
    endtask : swap_addr

    task automatic sw_regs(input logic sw, input logic [1:0] bk);
        logic [31:0] d;
        logic [1:0]  r;
        axi_write(12'h0dc, sw ? 32'h0 : 32'h10, r);
        check("swap wr resp", {30'h0, r}, 32'h0);
        axi_read(12'h0dc, d, r);
        check("swap after wr", {31'h0, d[4]}, 32'h1);
        if (!sw) swap_addr(1'b1, bk);
        axi_write(12'h0e0, 32'hffff_ffff, r);
        check("ro write resp", {30'h0, r}, 32'h2);
        axi_read(12'hffc, d, r);
        check("unmapped resp", {30'h0, r}, 32'h2);
        check("unmapped data", d, 32'h0);
    endtask : sw_regs

    initial begin
        rst = 1'b1;
        resume_well_reset_n = 1'b0;
        core_power_good = 1'b0;
        drive_en = 1'b1;
        strap_lvl = 3'h0;
        soft_word = 32'h0;
        flash_wait = 8'h00;
        fetch_addr_in = 32'h0;
        fetch_is_hub = 1'b0;
        s_axi_awaddr = 12'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 12'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            boot(boot_tbl[i], 8'(i * 7));
            swap_addr(boot_tbl[i][4], boot_tbl[i][1:0]);
            sw_regs(boot_tbl[i][4], boot_tbl[i][1:0]);
        end
        report_and_stop();
    end

    // the four boots take under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        report_and_stop();
    end
endmodule : boot_strap_sampler_tb

// *** bench/strap_board_model.sv ***
// board side of the sampler: strap drivers, floating pins and soft strap flash
`timescale 1ns/1ps
module strap_board_model (
    input  wire logic        clk_sys,
    input  wire logic        drive_en,
    input  wire logic [2:0]  strap_lvl,
    input  wire logic [2:0]  pd_en,
    output logic      [2:0]  strap_pin,
    input  wire logic        flash_rd_req,
    input  wire logic [31:0] flash_rd_addr,
    output logic             flash_rd_valid,
    output logic      [31:0] flash_rd_data,
    input  wire logic [31:0] soft_word,
    input  wire logic [31:0] soft_addr,
    input  wire logic [7:0]  flash_wait
);
    logic       float_q;
    logic [7:0] wait_cnt;

    initial begin
        float_q = 1'b0;
        wait_cnt = 8'h00;
        flash_rd_valid = 1'b0;
    end

    always @(posedge clk_sys) begin
        float_q <= ~float_q;
    end

    // a released pin with no pull-down floats: toggle so no stale level survives
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (drive_en) begin
                strap_pin[i] = strap_lvl[i];
            end else if (pd_en[i]) begin
                strap_pin[i] = 1'b0;
            end else begin
                strap_pin[i] = float_q ^ i[0];
            end
        end
    end

    // flash_wait sets how slow the flash is; zero answers on the next edge
    always @(posedge clk_sys) begin
        flash_rd_valid <= 1'b0;
        if (flash_rd_req && !flash_rd_valid) begin
            if (wait_cnt == flash_wait) begin
                flash_rd_valid <= 1'b1;
                wait_cnt <= 8'h00;
            end else begin
                wait_cnt <= wait_cnt + 8'h01;
            end
        end
    end

    // idle bus or wrong address returns the inverted word
    assign flash_rd_data = (flash_rd_valid && flash_rd_addr == soft_addr) ? soft_word : ~soft_word;
endmodule : strap_board_model

// *** hdl/boot_strap_map.svh ***
// offsets, fields, reset values and timing counts of the strap sampler
`ifndef BOOT_STRAP_MAP_SVH
`define BOOT_STRAP_MAP_SVH

`define BSS_OFF_SWAP_CTRL    12'h0dc
`define BSS_OFF_STRAP_STAT   12'h0e0
`define BSS_OFF_SOFT_STRAP   12'h0e4
`define BSS_OFF_FLASH_DATA   12'h0e8
`define BSS_BIT_SWAP         4
`define BSS_BIT_NOREBOOT     0
`define BSS_BIT_ENCRYPT      1
`define BSS_BIT_SOFT_DONE    2
`define BSS_BIT_ME_RST       3
`define BSS_BIT_HOST_RST     4
`define BSS_FLD_BLK_LO       0
`define BSS_FLD_BLK_HI       1
`define BSS_RST_SWAP         1'b0
`define BSS_RST_NOREBOOT     1'b0
`define BSS_RST_ENCRYPT      1'b0
`define BSS_RST_BLK_SIZE     2'h0
`define BSS_PCI_CLK_NS       30
`define BSS_SETUP_PCI_CLKS   4
`define BSS_CLK_NS           4
`define BSS_SETUP_CYCLES     ((`BSS_SETUP_PCI_CLKS * `BSS_PCI_CLK_NS + `BSS_CLK_NS - 1) / `BSS_CLK_NS)
`define BSS_A16              5'h10
`define BSS_UPPER_MASK       32'hfffe_0000

`endif

// *** hdl/boot_strap_pkg.sv ***
// types shared by the strap sampler files
package boot_strap_pkg;
    typedef enum logic [1:0] {
        SOFT_IDLE  = 2'b00,
        SOFT_FETCH = 2'b01,
        SOFT_DONE  = 2'b10
    } soft_state_t;

    typedef struct packed {
        logic       swap;
        logic       noreboot;
        logic       encrypt;
        logic [1:0] blk_size;
    } straps_t;

    typedef struct packed {
        logic        req;
        logic [31:0] addr;
    } flash_req_t;
endpackage : boot_strap_pkg

// *** hdl/boot_strap_sampler.sv ***
// strap sampler top: straps, soft strap fetch, swap address logic, axi4-lite regs
`timescale 1ns/1ps
`include "boot_strap_map.svh"
module boot_strap_sampler (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        resume_well_reset_n,
    input  wire logic        core_power_good,
    input  wire logic        speaker_swap_strap_pin,
    input  wire logic        noreboot_strap_pin,
    input  wire logic        encrypt_strap_pin,
    output logic             speaker_swap_pd_en,
    output logic             noreboot_pd_en,
    output logic             encrypt_pd_en,
    output logic             flash_rd_req,
    output logic [31:0]      flash_rd_addr,
    input  wire logic        flash_rd_valid,
    input  wire logic [31:0] flash_rd_data,
    input  wire logic [31:0] fetch_addr_in,
    input  wire logic        fetch_is_hub,
    output logic [31:0]      fetch_addr_out,
    output logic             me_reset_n,
    output logic             host_reset_n,
    output logic             watchdog_reboot_en,
    output logic             encrypt_suite_en,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    parameter logic [31:0] SOFT_STRAP_ADDR = 32'h0000_0100;

    boot_strap_pkg::straps_t     straps;
    boot_strap_pkg::soft_state_t soft_state;
    logic [1:0]  rsm_sync;
    logic [1:0]  pwr_sync;
    logic        swap_pin_val;
    logic        noreboot_val;
    logic        encrypt_val;
    logic        swap_sw;
    logic [31:0] soft_word;
    logic        soft_done;
    logic [11:0] aw_addr;
    logic        aw_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_have;
    logic        wr_go;

    // qualifiers are async pins: two flops before any logic; latches find the edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rsm_sync <= 2'h0;
            pwr_sync <= 2'h0;
        end else begin
            rsm_sync <= {rsm_sync[0], resume_well_reset_n};
            pwr_sync <= {pwr_sync[0], core_power_good};
        end
    end

    strap_pin_latch u_swap (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .pin         (speaker_swap_strap_pin),
        .qual_sync   (pwr_sync[1]),
        .default_val (`BSS_RST_SWAP),
        .value       (swap_pin_val),
        .pulldown_en (speaker_swap_pd_en)
    );
    strap_pin_latch u_noreboot (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .pin         (noreboot_strap_pin),
        .qual_sync   (pwr_sync[1]),
        .default_val (`BSS_RST_NOREBOOT),
        .value       (noreboot_val),
        .pulldown_en (noreboot_pd_en)
    );
    strap_pin_latch u_encrypt (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .pin         (encrypt_strap_pin),
        .qual_sync   (rsm_sync[1]),
        .default_val (`BSS_RST_ENCRYPT),
        .value       (encrypt_val),
        .pulldown_en (encrypt_pd_en)
    );

    // one driver for the whole struct rather than one per field
    assign straps = '{swap:     swap_pin_val | swap_sw,
                      noreboot: noreboot_val,
                      encrypt:  encrypt_val,
                      blk_size: soft_word[`BSS_FLD_BLK_HI:`BSS_FLD_BLK_LO]};
    assign watchdog_reboot_en = !straps.noreboot;
    assign encrypt_suite_en   = straps.encrypt;

    // soft strap fetch after resume reset; core resets held until it completes
    always_ff @(posedge clk_sys) begin
        if (rst || !rsm_sync[1]) begin
            soft_state   <= boot_strap_pkg::SOFT_IDLE;
            soft_word    <= 32'h0000_0000;
            flash_rd_req <= 1'b0;
        end else begin
            unique case (soft_state)
                boot_strap_pkg::SOFT_IDLE: begin
                    flash_rd_req <= 1'b1;
                    soft_state   <= boot_strap_pkg::SOFT_FETCH;
                end
                boot_strap_pkg::SOFT_FETCH: begin
                    if (flash_rd_valid) begin
                        flash_rd_req <= 1'b0;
                        soft_word    <= flash_rd_data;
                        soft_state   <= boot_strap_pkg::SOFT_DONE;
                    end
                end
                boot_strap_pkg::SOFT_DONE: begin
                    flash_rd_req <= 1'b0;
                end
                default: soft_state <= boot_strap_pkg::SOFT_IDLE;
            endcase
        end
    end
    assign flash_rd_addr   = SOFT_STRAP_ADDR;
    assign soft_done       = (soft_state == boot_strap_pkg::SOFT_DONE);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            me_reset_n   <= 1'b0;
            host_reset_n <= 1'b0;
        end else begin
            me_reset_n   <= soft_done;
            host_reset_n <= soft_done && pwr_sync[1];
        end
    end

    // chooses a16/a17/a18 and inverts it for upper-block hub or flash fetches
    function automatic logic [31:0] swap_addr(input logic [31:0] a,
                                              input logic [1:0]  blk);
        logic [4:0] bitpos;
        bitpos = `BSS_A16 + ((blk > 2'h2) ? 5'h2 : {3'h0, blk});
        swap_addr = a ^ (32'h1 << bitpos);
    endfunction : swap_addr

    always_ff @(posedge clk_sys) begin
        if (rst)
            fetch_addr_out <= 32'h0000_0000;
        else if (straps.swap && (!fetch_is_hub ||
                 ((fetch_addr_in & `BSS_UPPER_MASK) == `BSS_UPPER_MASK)))
            fetch_addr_out <= swap_addr(fetch_addr_in, straps.blk_size);
        else
            fetch_addr_out <= fetch_addr_in;
    end

    // axi4-lite write side: address and data taken in either order
    assign s_axi_awready = !aw_have && !s_axi_bvalid;
    assign s_axi_wready  = !w_have && !s_axi_bvalid;
    assign wr_go         = aw_have && w_have && !s_axi_bvalid;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            aw_addr <= 12'h000;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_have <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_have <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[11:2] == `BSS_OFF_SWAP_CTRL >> 2) ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // software may set swap; a strap-set swap stays until power-good drops
    always_ff @(posedge clk_sys) begin
        if (rst || !pwr_sync[1])
            swap_sw <= `BSS_RST_SWAP;
        else if (wr_go && aw_addr[11:2] == `BSS_OFF_SWAP_CTRL >> 2 && w_strb[0])
            swap_sw <= w_data[`BSS_BIT_SWAP];
    end

    function automatic logic [31:0] reg_read(input logic [11:0] a);
        reg_read = 32'h0000_0000;
        unique case (a[11:2])
            10'(`BSS_OFF_SWAP_CTRL >> 2):
                reg_read[`BSS_BIT_SWAP] = straps.swap;
            10'(`BSS_OFF_STRAP_STAT >> 2): begin
                reg_read[`BSS_BIT_NOREBOOT]  = straps.noreboot;
                reg_read[`BSS_BIT_ENCRYPT]   = straps.encrypt;
                reg_read[`BSS_BIT_SOFT_DONE] = soft_done;
                reg_read[`BSS_BIT_ME_RST]    = me_reset_n;
                reg_read[`BSS_BIT_HOST_RST]  = host_reset_n;
            end
            10'(`BSS_OFF_SOFT_STRAP >> 2):
                reg_read[1:0] = straps.blk_size;
            10'(`BSS_OFF_FLASH_DATA >> 2):
                reg_read = soft_word;
            default: reg_read = 32'h0000_0000;
        endcase
    endfunction : reg_read

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a[11:2] >= 10'(`BSS_OFF_SWAP_CTRL >> 2)) &&
                 (a[11:2] <= 10'(`BSS_OFF_FLASH_DATA >> 2));
    endfunction : mapped

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= reg_read(s_axi_araddr);
            s_axi_rresp  <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    a_swap_sticky:
        assert property (@(posedge clk_sys) disable iff (rst)
            (swap_pin_val && pwr_sync[1]) |=> straps.swap)
        else $error("strap swap cleared before reboot");

    a_reset_order:
        assert property (@(posedge clk_sys) disable iff (rst)
            (me_reset_n || host_reset_n) |-> $past(soft_done))
        else $error("reset released before soft straps read");

    a_noreboot_map:
        assert property (@(posedge clk_sys) disable iff (rst)
            !pwr_sync[1] |=> watchdog_reboot_en)
        else $error("watchdog reboot not back to default");

    a_swap_invert:
        assert property (@(posedge clk_sys) disable iff (rst)
            (straps.swap && !fetch_is_hub && straps.blk_size == 2'h0)
            |=> (fetch_addr_out[16] != $past(fetch_addr_in[16])))
        else $error("a16 not inverted in swap mode");

    a_no_swap_pass:
        assert property (@(posedge clk_sys) disable iff (rst)
            !straps.swap |=> (fetch_addr_out == $past(fetch_addr_in)))
        else $error("address changed with swap off");
endmodule : boot_strap_sampler

// *** hdl/strap_pin_latch.sv ***
// one strap pin: sync, qualifier edge capture and weak pull-down control
`timescale 1ns/1ps
`include "boot_strap_map.svh"
module strap_pin_latch (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic pin,
    input  wire logic qual_sync,
    input  wire logic default_val,
    output logic      value,
    output logic      pulldown_en
);
    logic       pin_meta;
    logic       pin_sync;
    logic       qual_d;
    logic [7:0] stable_cnt;
    logic       setup_ok;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= pin;
            pin_sync <= pin_meta;
        end
    end

    // counts cycles since the pin last differed from value with the qualifier low, only a hint for the setup window
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            qual_d     <= 1'b0;
            stable_cnt <= 8'h00;
        end else begin
            qual_d <= qual_sync;
            if (pin_sync != value && !qual_sync)
                stable_cnt <= 8'h00;
            else if (stable_cnt != 8'hff)
                stable_cnt <= stable_cnt + 8'h01;
        end
    end
    assign setup_ok = (stable_cnt >= 8'(`BSS_SETUP_CYCLES));

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            value <= 1'b0;
        end else if (!qual_sync) begin
            value <= default_val;
        end else if (!qual_d) begin
            value <= pin_sync;
        end
    end

    // pull-down only while the qualifier is low; released after it rises
    always_ff @(posedge clk_sys) begin
        if (rst)
            pulldown_en <= 1'b1;
        else
            pulldown_en <= !qual_sync;
    end

    a_hold_after_edge:
        assert property (@(posedge clk_sys) disable iff (rst)
            (qual_d && qual_sync) |=> (value == $past(value)))
        else $error("strap value moved while qualifier high");

    a_capture_edge:
        assert property (@(posedge clk_sys) disable iff (rst)
            (qual_sync && !qual_d) |=> (value == $past(pin_sync)))
        else $error("strap value not taken at qualifier edge");

    a_pull_release:
        assert property (@(posedge clk_sys) disable iff (rst)
            (qual_sync ##1 qual_sync) |-> !pulldown_en)
        else $error("pull-down still on after qualifier rose");

    wire unused_ok = setup_ok;
endmodule : strap_pin_latch
